//--- src/sar_adc_ctrl.sv
// Purpose: Control logic of a 10-bit successive-approximation converter with Wishbone access.
// Assumes: Classic Wishbone, 32-bit data, byte offsets; analog parts are outside.
// Notes: The comparator answer and RC clock arrive on pins and are synchronised here.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`default_nettype none
// How it works
// - Ten-bit result by successive approximation, stored in high and low result registers.
// - Channel field selects which input feeds the sample-and-hold.
// - Two reference bits choose positive and negative references independently.
// - Clock field: 00 div2, 01 div8, 10 div32, 11 internal RC.
// - One bit period per conversion clock; full conversion takes 11 periods.
// - Done flag sets on every completion, regardless of interrupt enable.
// - Enabled completion interrupt wakes a sleeping device.
// - Justify bit places result left or right in the register pair.
// - Works only while enabled; writing go starts a conversion.
// - Completion clears go, sets flag, loads new result.
// - Clearing go early aborts; result registers keep the previous value.
// - After abort wait two conversion periods, then acquire selected channel again.
// - Reset returns registers to reset state and stops conversion.
// - Sleep conversion only with RC clock; RC start deferred one instruction cycle.
// - Sleeping with interrupt disabled powers down after completion, enable stays set.
// - Non-RC clock: sleep aborts conversion and powers down, enable stays set.
// - Compare trigger sets go, starts conversion, and resets the timer.
// - Control A: clock 7-6, channel 5-2, go bit 1, enable bit 0.
// - Codes 0-13 inputs, 14 comparator reference, 15 fixed reference.
// - Right: bits 9:8 in high 1:0; left: 9:2 high, 1:0 low top.
// - Negative ref bit one selects pin; positive ref bit one selects pin.
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core and trigger events
  input wire logic sleep_i,
  input wire logic instr_cycle_i,
  input wire logic special_trigger_i,
  output logic timer_reset_o,
  output logic wake_o,
  // Analog front end
  input wire logic rc_clk_i,
  input wire logic cmp_high_i,
  output logic [3:0] channel_sel_o,
  output logic positive_ref_select_o,
  output logic negative_ref_select_o,
  output logic [9:0] dac_code_o,
  output logic sample_o,
  output logic powered_o
);
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [9:0] res_ff;
  logic done_flag_ff;
  logic irq_en_ff;
  logic [1:0] rc_sync_ff;
  logic [1:0] cmp_sync_ff;
  logic pending_ff;
  logic down_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic tick;
  logic wr;
  logic rd;
  logic go_wr_set;
  logic go_wr_clr;
  logic rc_sel;
  sar_seq_if sq ();

  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_ff;
  assign rd = cyc_i && stb_i && !we_i && !ack_ff;
  assign rc_sel = (ctrl_a_ff[`CA_CLK_HI:`CA_CLK_LO] == 2'b11);
  assign go_wr_set = wr && adr_i == `OFS_CTRL_A && dat_i[`CA_GO] && dat_i[`CA_EN]
    && ctrl_a_ff[`CA_EN];
  assign go_wr_clr = wr && adr_i == `OFS_CTRL_A && !dat_i[`CA_GO];

  // Pin inputs pass two flops before any use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rc_sync_ff <= 2'b00;
      cmp_sync_ff <= 2'b00;
    end
    else
    begin
      rc_sync_ff <= {rc_sync_ff[0], rc_clk_i};
      cmp_sync_ff <= {cmp_sync_ff[0], cmp_high_i};
    end
  end

  sar_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(clk_sel_t'(ctrl_a_ff[`CA_CLK_HI:`CA_CLK_LO])),
    .rc_level_i(rc_sync_ff[1]),
    .tick_o(tick)
  );

  sar_sequencer u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sq(sq.seq)
  );

  // Sequencer steps through hold, bits and recovery on conversion-clock ticks; start and abort act at once
  assign sq.tick = tick;
  assign sq.cmp_high = cmp_sync_ff[1];
  // Start after any RC deferral, abort on software clear, disable or sleep with a non-RC clock.
  // Held back while busy, so a request during recovery is not lost.
  assign sq.start = pending_ff && ctrl_a_ff[`CA_EN] && !down_ff && !sq.busy
    && (!rc_sel || instr_cycle_i);
  assign sq.abort = (go_wr_clr && ctrl_a_ff[`CA_GO]) || !ctrl_a_ff[`CA_EN]
    || (sleep_i && !rc_sel);

  // A start request waits here until the sequencer is free
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sq.abort || sq.start)
      pending_ff <= 1'b0;
    else if (go_wr_set || (special_trigger_i && ctrl_a_ff[`CA_EN]))
      pending_ff <= 1'b1;
  end

  // Control A; hardware clears go on completion or abort
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_a_ff <= `CA_RESET;
    else
    begin
      if (wr && adr_i == `OFS_CTRL_A)
      begin
        ctrl_a_ff <= dat_i[7:0];
        // Go only sticks when the converter was already on
        ctrl_a_ff[`CA_GO] <= go_wr_set || (ctrl_a_ff[`CA_GO] && dat_i[`CA_GO]);
      end
      if (special_trigger_i && ctrl_a_ff[`CA_EN])
        ctrl_a_ff[`CA_GO] <= 1'b1;
      if (sq.done || (sleep_i && !rc_sel) || !ctrl_a_ff[`CA_EN])
        ctrl_a_ff[`CA_GO] <= 1'b0;
    end
  end

  // Control B: justify and reference bits only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_b_ff <= `CB_RESET;
    else if (wr && adr_i == `OFS_CTRL_B)
      ctrl_b_ff <= dat_i[7:0] & `CB_MASK;
  end

  // Result updates only on completion, so aborts keep the old value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      res_ff <= 10'h000;
    else if (sq.done)
      res_ff <= sq.result;
  end

  // Done flag: completion wins over a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_flag_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end
    else
    begin
      if (wr && adr_i == `OFS_FLAGS)
      begin
        done_flag_ff <= dat_i[`FL_DONE];
        irq_en_ff <= dat_i[`FL_IRQ_EN];
      end
      if (sq.done)
        done_flag_ff <= 1'b1;
    end
  end

  // Power-down after sleep completion without interrupt, or on sleep with non-RC clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !sleep_i)
      down_ff <= 1'b0;
    else if ((sq.done && !irq_en_ff) || !rc_sel)
      down_ff <= 1'b1;
  end

  // Registered outputs toward the analog side and the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_sel_o <= 4'h0;
      positive_ref_select_o <= 1'b0;
      negative_ref_select_o <= 1'b0;
      dac_code_o <= 10'h000;
      sample_o <= 1'b0;
      powered_o <= 1'b0;
      wake_o <= 1'b0;
      timer_reset_o <= 1'b0;
    end
    else
    begin
      channel_sel_o <= ctrl_a_ff[`CA_CHS_HI:`CA_CHS_LO];
      positive_ref_select_o <= ctrl_b_ff[`CB_PREF];
      negative_ref_select_o <= ctrl_b_ff[`CB_NREF];
      dac_code_o <= sq.trial;
      // Acquire whenever enabled, not converting and not powered down; resumes after abort recovery
      sample_o <= ctrl_a_ff[`CA_EN] && !sq.busy && !down_ff;
      powered_o <= ctrl_a_ff[`CA_EN] && !down_ff;
      wake_o <= sleep_i && sq.done && irq_en_ff;
      timer_reset_o <= special_trigger_i && ctrl_a_ff[`CA_EN];
    end
  end

  // Wishbone read mux and one-cycle ack; unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
      if (rd)
      begin
        case (adr_i)
          `OFS_CTRL_A: dat_ff <= {24'h000000, ctrl_a_ff};
          `OFS_CTRL_B: dat_ff <= {24'h000000, ctrl_b_ff};
          `OFS_RES_HI: dat_ff <= {24'h000000, ctrl_b_ff[`CB_JUSTIFY]
            ? {6'h00, res_ff[9:8]} : res_ff[9:2]};
          `OFS_RES_LO: dat_ff <= {24'h000000, ctrl_b_ff[`CB_JUSTIFY]
            ? res_ff[7:0] : {res_ff[1:0], 6'h00}};
          `OFS_FLAGS: dat_ff <= {30'h0, irq_en_ff, done_flag_ff};
          `OFS_STATUS: dat_ff <= {29'h0, down_ff, pending_ff, sq.busy};
          default: dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
endmodule
`default_nettype wire

//--- src/sar_adc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts for the converter control.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes: Included by its bare name.
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// Register byte offsets
`define OFS_CTRL_A 6'h00
`define OFS_CTRL_B 6'h04
`define OFS_RES_HI 6'h08
`define OFS_RES_LO 6'h0c
`define OFS_FLAGS 6'h10
`define OFS_STATUS 6'h14

// Control A fields
`define CA_CLK_HI 7
`define CA_CLK_LO 6
`define CA_CHS_HI 5
`define CA_CHS_LO 2
`define CA_GO 1
`define CA_EN 0
`define CA_RESET 8'h00

// Control B fields
`define CB_JUSTIFY 7
`define CB_NREF 5
`define CB_PREF 4
`define CB_MASK 8'hb0
`define CB_RESET 8'h00

// Flag register fields
`define FL_DONE 0
`define FL_IRQ_EN 1

// Clock dividers (system clocks per conversion-clock period)
`define DIV_2 8'd2
`define DIV_8 8'd8
`define DIV_32 8'd32

// Conversion length and abort recovery in conversion-clock periods
`define CONV_PERIODS 4'd11
`define ABORT_PERIODS 4'd2

`endif

//--- src/sar_adc_pkg.sv
// Purpose: Types shared by the converter control modules.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in sar_adc_map.svh.
package sar_adc_pkg;
  typedef enum logic [1:0] {CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC} clk_sel_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_BITS, SEQ_RECOVER} seq_state_t;
endpackage

//--- src/sar_seq_if.sv
// Purpose: Signals between the control block and the approximation sequencer.
// Assumes: One clock domain.
// Notes: Tick marks one conversion-clock period.
`timescale 1ns/1ps
`default_nettype none
interface sar_seq_if;
  logic tick;
  logic start;
  logic abort;
  logic busy;
  logic done;
  logic [9:0] result;
  logic [9:0] trial;
  logic cmp_high;
  modport ctrl (output tick, output start, output abort, input busy, input done,
    input result, input trial, output cmp_high);
  modport seq (input tick, input start, input abort, output busy, output done,
    output result, output trial, input cmp_high);
endinterface
`default_nettype wire

//--- src/sar_tick_gen.sv
// Purpose: Produces one pulse per conversion-clock period.
// Assumes: RC clock pin already synchronised by the caller.
// Notes: Divider restarts when the selection changes to avoid a runt period.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`default_nettype none
module sar_tick_gen
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Selection
  input wire sar_adc_pkg::clk_sel_t sel_i,
  input wire logic rc_level_i,
  // Period pulse
  output logic tick_o
);
  logic [7:0] cnt_ff;
  logic [7:0] div;
  logic rc_last_ff;
  sar_adc_pkg::clk_sel_t sel_last_ff;

  // Divide ratio for the system clock options
  always_comb
  begin
    case (sel_i)
      CLK_DIV2: div = `DIV_2;
      CLK_DIV8: div = `DIV_8;
      default: div = `DIV_32;
    endcase
  end

  // Divider counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sel_i != sel_last_ff || cnt_ff == div - 8'd1)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end

  // Remember selection and RC level for edge detect
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_last_ff <= CLK_DIV2;
      rc_last_ff <= 1'b0;
    end
    else
    begin
      sel_last_ff <= sel_i;
      rc_last_ff <= rc_level_i;
    end
  end

  // Tick on divider wrap, or on a rising edge of the RC clock
  assign tick_o = (sel_i == CLK_RC) ? (rc_level_i && !rc_last_ff)
                : (sel_i == sel_last_ff && cnt_ff == div - 8'd1);
endmodule
`default_nettype wire

//--- src/sar_sequencer.sv
// Purpose: Successive-approximation sequencer, one step per conversion-clock period.
// Assumes: Comparator answer valid one period after the trial code is presented.
// Notes: Busy covers hold, bit periods and the abort recovery.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`default_nettype none
module sar_sequencer
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control side
  sar_seq_if.seq sq
);
  seq_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [9:0] sar_ff;
  logic [9:0] bit_ff;
  logic done_ff;

  // Main sequence: 1 hold period plus 10 bit periods, MSB first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= SEQ_IDLE;
      cnt_ff <= 4'h0;
      sar_ff <= 10'h000;
      bit_ff <= 10'h000;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (sq.abort && state_ff != SEQ_IDLE && state_ff != SEQ_RECOVER)
      begin
        state_ff <= SEQ_RECOVER;
        cnt_ff <= 4'h0;
      end
      else
      begin
        case (state_ff)
          SEQ_IDLE:
          begin
            if (sq.start)
            begin
              state_ff <= SEQ_HOLD;
              sar_ff <= 10'h200;
              bit_ff <= 10'h200;
            end
          end
          SEQ_HOLD:
          begin
            if (sq.tick)
            begin
              state_ff <= SEQ_BITS;
              cnt_ff <= 4'h1;
            end
          end
          SEQ_BITS:
          begin
            if (sq.tick)
            begin
              // Keep or drop the trial bit, then try the next lower one
              sar_ff <= (sq.cmp_high ? sar_ff : (sar_ff & ~bit_ff)) | (bit_ff >> 1);
              bit_ff <= bit_ff >> 1;
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `CONV_PERIODS - 4'd1)
              begin
                state_ff <= SEQ_IDLE;
                done_ff <= 1'b1;
              end
            end
          end
          SEQ_RECOVER:
          begin
            if (sq.tick)
            begin
              cnt_ff <= cnt_ff + 4'h1;
              if (cnt_ff == `ABORT_PERIODS - 4'd1)
                state_ff <= SEQ_IDLE;
            end
          end
          default: state_ff <= SEQ_IDLE;
        endcase
      end
    end
  end

  assign sq.busy = (state_ff != SEQ_IDLE);
  assign sq.done = done_ff;
  assign sq.result = sar_ff;
  assign sq.trial = sar_ff;
endmodule
`default_nettype wire

//--- test/sar_adc_ctrl_properties.sv
// Purpose: Bus and event properties of the converter control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound from the testbench top; sees only top-level ports.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`default_nettype none
module sar_adc_ctrl_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Events and copies
  input wire logic sleep_i,
  input wire logic special_trigger_i,
  input wire logic timer_reset_o,
  input wire logic wake_o,
  input wire logic [3:0] channel_sel_o,
  input wire logic positive_ref_select_o,
  input wire logic negative_ref_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_a;
  logic wr_b;
  // Accepted control writes; the copies lag by up to two edges, so check at two
  assign wr_a = ack_o && we_i && sel_i[0] && adr_i == `OFS_CTRL_A;
  assign wr_b = ack_o && we_i && sel_i[0] && adr_i == `OFS_CTRL_B;
  property p_ack_answer;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped_zero;
    ack_o && !we_i && adr_i > `OFS_STATUS |-> dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
  property p_chan_copy;
    wr_a |-> ##2 channel_sel_o == $past(dat_i[5:2], 2);
  endproperty
  a_chan_copy: assert property (p_chan_copy) else $error("channel output wrong");
  property p_ref_copy;
    wr_b |-> ##2 {negative_ref_select_o, positive_ref_select_o} == $past(dat_i[5:4], 2);
  endproperty
  a_ref_copy: assert property (p_ref_copy) else $error("reference outputs wrong");
  property p_trigger_timer;
    timer_reset_o |-> $past(special_trigger_i);
  endproperty
  a_trigger_timer: assert property (p_trigger_timer) else $error("timer reset uncaused");
  property p_wake_sleep;
    wake_o |-> $past(sleep_i);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
endmodule
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench for the converter control over Wishbone.
// Assumes: Comparator answer modelled from the trial code against a target.
// Notes: RC clock comes from a bench counter, 26 system clocks a period.
`timescale 1ns/1ps
`include "sar_adc_map.svh"
`default_nettype none
module testbench;
  import sar_adc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, timer_reset_o, wake_o, positive_ref_select_o, negative_ref_select_o;
  logic sleep_i = 1'b0, instr_cycle_i = 1'b0, special_trigger_i = 1'b0;
  logic rc_clk_i = 1'b0, cmp_high_i = 1'b0, sample_o, powered_o;
  logic [3:0] channel_sel_o;
  logic [9:0] dac_code_o, target = 10'h000;
  logic [4:0] rc_cnt = 5'h00;
  int bad_count = 0, check_count = 0, n;
  int per[4] = '{2, 8, 32, 26};
  // Div2 and div8 get all-ones; for div2 the synchronised comparator lags a two-clock period
  logic [9:0] tv[4] = '{10'h3ff, 10'h3ff, 10'h15a, 10'h000};
  sar_adc_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .sleep_i, .instr_cycle_i, .special_trigger_i, .timer_reset_o, .wake_o,
    .rc_clk_i, .cmp_high_i, .channel_sel_o, .positive_ref_select_o, .negative_ref_select_o,
    .dac_code_o, .sample_o, .powered_o);
  // Clock
  always #20 clk_i = ~clk_i;
  // RC clock, instruction pulses and comparator (keep the bit while input >= trial)
  always @(posedge clk_i)
  begin
    rc_cnt <= (rc_cnt == 5'd25) ? 5'd0 : rc_cnt + 5'd1;
    rc_clk_i <= rc_cnt >= 5'd13;
    instr_cycle_i <= rc_cnt[1:0] == 2'b00;
    cmp_high_i <= dac_code_o <= target;
  end
  // Comparison with mismatch report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; held until ack is sampled, then released
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 50)
      bad_count++;
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00, 4'hf);
    chk(nm, e, q);
  endtask
  // Enable first, then set go in a second write
  task automatic start(input logic [1:0] cs);
    wb(1'b1, `OFS_CTRL_A, {cs, 4'd5, 2'b01}, 4'hf);
    repeat (4) @(posedge clk_i);
    wb(1'b1, `OFS_CTRL_A, {cs, 4'd5, 2'b11}, 4'hf);
  endtask
  // Poll go until clear; n returns elapsed system clocks
  task automatic wait_done;
    time t0;
    t0 = $time;
    q = 32'h2;
    while (q[1] === 1'b1 && $time - t0 < 120000)
      wb(1'b0, `OFS_CTRL_A, 8'h00, 4'hf);
    n = int'(($time - t0) / 40);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl_a", `OFS_CTRL_A, 32'h0);
    rdchk("ctrl_b", `OFS_CTRL_B, 32'h0);
    rdchk("unmapped", 6'h18, 32'h0);
    wb(1'b1, `OFS_CTRL_B, 8'hff, 4'hf);
    rdchk("ctrl_b_mask", `OFS_CTRL_B, 32'hb0);
    wb(1'b1, `OFS_CTRL_A, 8'hff, 4'he);
    rdchk("no_sel", `OFS_CTRL_A, 32'h0);
    wb(1'b1, `OFS_CTRL_A, 8'h57, 4'hf);
    rdchk("go_with_en", `OFS_CTRL_A, 32'h55);
    // Each clock choice, right justified, boundary codes and one mid-range code
    for (int i = 0; i < 4; i++)
    begin
      target = tv[i];
      start(2'(i));
      wait_done();
      chk("conv_time", 1, 32'(n >= 10 * per[i] && n <= 12 * per[i] + 60));
      rdchk("res_hi", `OFS_RES_HI, {30'h0, tv[i][9:8]});
      rdchk("res_lo", `OFS_RES_LO, {24'h0, tv[i][7:0]});
      rdchk("flag", `OFS_FLAGS, 32'h1);
      wb(1'b1, `OFS_FLAGS, 8'h00, 4'hf);
    end
    // Left justified, flag persists until software clears it
    wb(1'b1, `OFS_CTRL_B, 8'h00, 4'hf);
    target = 10'h2c7;
    start(2'd1);
    wait_done();
    repeat (50) @(posedge clk_i);
    rdchk("left_hi", `OFS_RES_HI, 32'hb1);
    rdchk("left_lo", `OFS_RES_LO, 32'hc0);
    rdchk("flag_kept", `OFS_FLAGS, 32'h1);
    wb(1'b1, `OFS_FLAGS, 8'h00, 4'hf);
    // Abort mid-conversion keeps the previous result
    target = 10'h100;
    start(2'd2);
    repeat (40) @(posedge clk_i);
    wb(1'b1, `OFS_CTRL_A, 8'h95, 4'hf);
    repeat (200) @(posedge clk_i);
    rdchk("abort_hi", `OFS_RES_HI, 32'hb1);
    rdchk("abort_flag", `OFS_FLAGS, 32'h0);
    chk("sample_after_abort", 1, 32'(sample_o));
    // Compare trigger sets go
    wb(1'b1, `OFS_CTRL_A, 8'h55, 4'hf);
    special_trigger_i <= 1'b1;
    @(posedge clk_i);
    special_trigger_i <= 1'b0;
    @(posedge clk_i);
    chk("timer_reset", 1, 32'(timer_reset_o));
    rdchk("trig_go", `OFS_CTRL_A, 32'h57);
    wait_done();
    rdchk("trig_flag", `OFS_FLAGS, 32'h1);
    // Sleep without interrupt powers down, enable kept, for div32 and RC
    for (int c = 2; c < 4; c++)
    begin
      wb(1'b1, `OFS_FLAGS, 8'h00, 4'hf);
      start(2'(c));
      repeat (20) @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (400) @(posedge clk_i);
      chk("powered", 0, 32'(powered_o));
      rdchk("en_kept", `OFS_CTRL_A, {24'h0, 2'(c), 6'h15});
      sleep_i <= 1'b0;
    end
    // RC conversion in sleep with interrupt enabled wakes the core
    wb(1'b1, `OFS_FLAGS, 8'h02, 4'hf);
    start(2'd3);
    sleep_i <= 1'b1;
    n = 0;
    while (wake_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("wake", 1, 32'(wake_o));
    sleep_i <= 1'b0;
    report_and_stop();
  end
endmodule
bind sar_adc_ctrl sar_adc_ctrl_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .sleep_i, .special_trigger_i, .timer_reset_o, .wake_o,
  .channel_sel_o, .positive_ref_select_o, .negative_ref_select_o);
`default_nettype wire
